//--- design/wwu_regs.svh
`ifndef WWU_REGS_SVH
`define WWU_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define WWU_OFS_WDOG_CTRL 8'h00
`define WWU_OFS_RST_FLAGS 8'h04
`define WWU_OFS_STATUS 8'h08
`define WWU_OFS_WAKE_EN 8'h0C
`define WWU_OFS_POWER_STATE 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WWU_CTRL_KEY_LSB 3
`define WWU_CTRL_KEY_MSB 7
`define WWU_CTRL_PER_LSB 0
`define WWU_CTRL_PER_MSB 2
`define WWU_FLAG_WDOG_KEY_BIT 0
`define WWU_STAT_TIMEOUT_BIT 0
`define WWU_STAT_POWER_DOWN_BIT 1

// ----------------------------------------
// Reset values and key codes
// ----------------------------------------
`define WWU_CTRL_RESET 8'h53
`define WWU_KEY_DISABLE 5'h15
`define WWU_KEY_ENABLE 5'h0A
`define WWU_WAKE_EN_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define WWU_CLK_PERIOD_NS 8
`define WWU_SRESET_DELAY_NS 1000
`define WWU_SRESET_CYCLES \
    ((`WWU_SRESET_DELAY_NS + `WWU_CLK_PERIOD_NS - 1) / `WWU_CLK_PERIOD_NS)

`endif

//--- design/wwu_pkg.sv
package wwu_pkg;

    typedef enum logic [1:0] {
        WWU_RUN,
        WWU_HALTED,
        WWU_OSC_WAIT
    } wwu_state_e;

    typedef logic [7:0] wwu_reg_t;

    // Division ratio of the slow RC clock per period code
    function automatic logic [18:0] wwuPeriodRatio(input logic [2:0] sel);
        case (sel)
            3'h0: wwuPeriodRatio = 19'h00100;
            3'h1: wwuPeriodRatio = 19'h00400;
            3'h2: wwuPeriodRatio = 19'h01000;
            3'h3: wwuPeriodRatio = 19'h04000;
            3'h4: wwuPeriodRatio = 19'h08000;
            3'h5: wwuPeriodRatio = 19'h10000;
            3'h6: wwuPeriodRatio = 19'h20000;
            default: wwuPeriodRatio = 19'h40000;
        endcase
    endfunction

endpackage

//--- design/wwu_wdog_counter.sv
`timescale 1ns/10ps
module wwu_wdog_counter (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic slowRcTick,
    input wire logic clear,
    input wire logic enable,
    input wire logic [2:0] periodSel,
    output logic timeoutPulse
);
    import wwu_pkg::*;

    logic [18:0] count_q;
    logic [18:0] countInc;

    assign countInc = count_q + 19'h00001;

    // ----------------------------------------
    // Counter on slow RC ticks
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_q <= 19'h00000;
            timeoutPulse <= 1'b0;
        end else begin
            timeoutPulse <= 1'b0;
            if (clear || !enable) begin
                count_q <= 19'h00000;
            end else if (slowRcTick) begin
                if (countInc >= wwuPeriodRatio(periodSel)) begin
                    count_q <= 19'h00000;
                    timeoutPulse <= 1'b1;
                end else begin
                    count_q <= countInc;
                end
            end
        end
    end
endmodule // wwu_wdog_counter

//--- design/wwu_watchdog_wakeup.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
`include "wwu_regs.svh"
// Overview of operation
// (R1) Watchdog counts slow RC ticks, timeout after power-of-two 2^8..2^18.
// (R2) Period codes 0..7 pick 2^8,10,12,14,15,16,17,18 ticks.
// (R3) Key 10101B disables, 01010B enables the watchdog.
// (R4) Any other key resets the device after the software-reset delay.
// (R5) Invalid key reset sets flag bit 0; only writing zero clears it.
// (R6) Control powers up as key 01010B, period 011.
// (R7) Timeout while running resets device and sets timeout flag.
// (R8) Timeout while halted sets timeout flag, resets only PC and SP.
// (R9) Invalid key, clear instruction, halt or reset pin low clear count.
// (R10) Port A fall, reset pin, interrupt or overflow wake the device.
// (R11) Reset pin wake gives full reset; overflow wake gives watchdog reset.
// (R12) Power-down flag cleared by power-up or clear, set by halt.
// (R13) Timeout wake sets timeout flag and resets only PC and SP.
// (R14) Per-pin Port A wake enables; such wake resumes after halt.
// (R15) Disabled interrupt or full stack: resume after halt, stays pending.
// (R16) Enabled interrupt with free stack: normal interrupt response.
// (R17) Interrupt already pending at halt cannot wake the device.
// (R18) Wake into fast mode runs only once fast oscillator is stable.
// (R19) Slow crystal has its own start-up; execution does not wait.
// (R20) Halt sets power-down, clears timeout flag and the watchdog.
// (R21) Counter counts from zero, times out at selected ratio.
module wwu_watchdog_wakeup #(
    parameter int NUM_IRQ = 8,
    parameter int PORTA_W = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slowRcTick,
    input wire logic clearWatchdogInstr,
    input wire logic haltInstr,
    input wire logic wakeToFast,
    input wire logic fastClockStable,
    input wire logic externalResetPinN,
    input wire logic resetPinSelect,
    input wire logic [PORTA_W-1:0] portAIn,
    input wire logic [NUM_IRQ-1:0] irqRequest,
    input wire logic [NUM_IRQ-1:0] irqEnable,
    input wire logic stackFull,
    output logic deviceReset,
    output logic pcSpReset,
    output logic fullReset,
    output logic resumeAfterHalt,
    output logic irqAccept,
    output logic [NUM_IRQ-1:0] irqWakeSource,
    output logic cpuRun
);
    import wwu_pkg::*;

    localparam int SRESET_CYCLES = `WWU_SRESET_CYCLES;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    wwu_state_e state_q;
    wwu_reg_t wdogCtrl_q;
    logic [PORTA_W-1:0] wakeEnable_q;
    logic wdogKeyResetFlag_q;
    logic timeoutFlag_q;
    logic powerDownFlag_q;
    logic [PORTA_W-1:0] portAPrev_q;
    logic [NUM_IRQ-1:0] irqArmed_q;
    logic keyResetPending_q;
    logic [15:0] keyDelayCnt_q;
    logic pendResume_q;
    logic pendIrq_q;
    logic [NUM_IRQ-1:0] pendIrqSrc_q;
    logic wdogTimeout;
    logic wdogClear;
    logic [4:0] enableKey;
    logic [2:0] periodSel;
    logic keyValid;
    logic wdogEnabled;
    logic apbSetup;
    logic apbWrite;
    logic apbRead;
    logic ctrlWrite;
    logic flagWrite;
    logic wakeWrite;
    logic resetPinLow;
    logic [PORTA_W-1:0] portAFall;
    logic [NUM_IRQ-1:0] irqNew;
    logic keyResetFire;
    logic halted;
    wwu_reg_t rdData;
    logic rdHit;

    assign enableKey = wdogCtrl_q[`WWU_CTRL_KEY_MSB:`WWU_CTRL_KEY_LSB];
    assign periodSel = wdogCtrl_q[`WWU_CTRL_PER_MSB:`WWU_CTRL_PER_LSB];
    assign keyValid = (enableKey == `WWU_KEY_ENABLE) ||
                      (enableKey == `WWU_KEY_DISABLE);
    assign wdogEnabled = (enableKey == `WWU_KEY_ENABLE); // [R3]
    assign halted = (state_q != WWU_RUN);

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pready && pwrite;
    assign apbRead = apbSetup && !pwrite;
    assign ctrlWrite = apbWrite && (paddr == `WWU_OFS_WDOG_CTRL);
    assign flagWrite = apbWrite && (paddr == `WWU_OFS_RST_FLAGS);
    assign wakeWrite = apbWrite && (paddr == `WWU_OFS_WAKE_EN);

    // ----------------------------------------
    // Read data mux
    // ----------------------------------------
    always_comb begin
        rdData = 8'h00;
        rdHit = 1'b1;
        case (paddr)
            `WWU_OFS_WDOG_CTRL: rdData = wdogCtrl_q;
            `WWU_OFS_RST_FLAGS: rdData = {7'h00, wdogKeyResetFlag_q};
            `WWU_OFS_STATUS: rdData = {6'h00, powerDownFlag_q, timeoutFlag_q};
            `WWU_OFS_WAKE_EN: rdData = 8'(wakeEnable_q);
            `WWU_OFS_POWER_STATE: rdData = {6'h00, pendIrq_q, halted};
            default: rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apbSetup;
            pslverr <= apbSetup && !rdHit;
            if (apbRead) begin
                prdata <= {24'h000000, rdData};
            end
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wdogCtrl_q <= `WWU_CTRL_RESET; // [R6]
        end else if (ctrlWrite) begin
            wdogCtrl_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // Port A wake enables
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wakeEnable_q <= PORTA_W'(`WWU_WAKE_EN_RESET);
        end else if (wakeWrite) begin
            wakeEnable_q <= pwdata[PORTA_W-1:0]; // [R14]
        end
    end

    // ----------------------------------------
    // Invalid key delayed reset
    // ----------------------------------------
    assign keyResetFire = keyResetPending_q &&
                          (keyDelayCnt_q == 16'(SRESET_CYCLES - 1));

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            keyResetPending_q <= 1'b0;
            keyDelayCnt_q <= 16'h0000;
        end else if (keyResetFire) begin
            keyResetPending_q <= 1'b0;
            keyDelayCnt_q <= 16'h0000;
        end else if (keyResetPending_q) begin
            keyDelayCnt_q <= keyDelayCnt_q + 16'h0001; // [R4]
        end else if (ctrlWrite) begin
            keyResetPending_q <= !((pwdata[7:3] == `WWU_KEY_ENABLE) ||
                                   (pwdata[7:3] == `WWU_KEY_DISABLE));
            keyDelayCnt_q <= 16'h0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wdogKeyResetFlag_q <= 1'b0;
        end else if (keyResetFire) begin
            wdogKeyResetFlag_q <= 1'b1; // [R5]
        end else if (flagWrite && !pwdata[`WWU_FLAG_WDOG_KEY_BIT]) begin
            wdogKeyResetFlag_q <= 1'b0; // [R5]
        end
    end

    // ----------------------------------------
    // Watchdog counter
    // ----------------------------------------
    assign resetPinLow = resetPinSelect && !externalResetPinN;
    assign wdogClear = (ctrlWrite && !((pwdata[7:3] == `WWU_KEY_ENABLE) ||
                        (pwdata[7:3] == `WWU_KEY_DISABLE))) ||
                       clearWatchdogInstr || haltInstr ||
                       resetPinLow; // [R9] [R20]

    wwu_wdog_counter u_counter (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .slowRcTick(slowRcTick), // [R1]
        .clear(wdogClear),
        .enable(wdogEnabled && keyValid),
        .periodSel(periodSel), // [R2] [R21]
        .timeoutPulse(wdogTimeout)
    );

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            timeoutFlag_q <= 1'b0;
        end else if (wdogTimeout) begin
            timeoutFlag_q <= 1'b1; // [R7] [R8] [R13]
        end else if (haltInstr && !halted) begin
            timeoutFlag_q <= 1'b0; // [R20]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            powerDownFlag_q <= 1'b0; // [R12]
        end else if (haltInstr && !halted) begin
            powerDownFlag_q <= 1'b1; // [R12] [R20]
        end else if (clearWatchdogInstr) begin
            powerDownFlag_q <= 1'b0; // [R12]
        end
    end

    // ----------------------------------------
    // Wake sources
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portAPrev_q <= '0;
        end else begin
            portAPrev_q <= portAIn;
        end
    end

    assign portAFall = portAPrev_q & ~portAIn & wakeEnable_q; // [R14]
    assign irqNew = irqRequest & irqArmed_q; // [R17]

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irqArmed_q <= '0;
        end else if (haltInstr && !halted) begin
            irqArmed_q <= ~irqRequest; // [R17]
        end
    end

    // ----------------------------------------
    // Halt and wake sequencing
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= WWU_RUN;
            pendResume_q <= 1'b0;
            pendIrq_q <= 1'b0;
            pendIrqSrc_q <= '0;
            deviceReset <= 1'b0;
            pcSpReset <= 1'b0;
            fullReset <= 1'b0;
            resumeAfterHalt <= 1'b0;
            irqAccept <= 1'b0;
            irqWakeSource <= '0;
            cpuRun <= 1'b1;
        end else begin
            deviceReset <= keyResetFire; // [R4]
            pcSpReset <= 1'b0;
            fullReset <= 1'b0;
            resumeAfterHalt <= 1'b0;
            irqAccept <= 1'b0;
            case (state_q)
                WWU_RUN: begin
                    cpuRun <= 1'b1;
                    if (wdogTimeout) begin
                        deviceReset <= 1'b1; // [R7]
                    end else if (haltInstr) begin
                        state_q <= WWU_HALTED;
                        cpuRun <= 1'b0;
                    end
                end
                WWU_HALTED: begin
                    if (resetPinLow) begin
                        fullReset <= 1'b1; // [R10] [R11]
                        state_q <= WWU_OSC_WAIT;
                        pendResume_q <= 1'b0;
                        pendIrq_q <= 1'b0;
                    end else if (wdogTimeout) begin
                        pcSpReset <= 1'b1; // [R8] [R11] [R13]
                        state_q <= WWU_OSC_WAIT;
                        pendResume_q <= 1'b0;
                        pendIrq_q <= 1'b0;
                    end else if (|irqNew) begin
                        state_q <= WWU_OSC_WAIT; // [R10]
                        irqWakeSource <= irqNew;
                        pendIrqSrc_q <= irqNew;
                        if (|(irqNew & irqEnable) && !stackFull) begin
                            pendIrq_q <= 1'b1; // [R16]
                            pendResume_q <= 1'b0;
                        end else begin
                            pendIrq_q <= 1'b0; // [R15]
                            pendResume_q <= 1'b1;
                        end
                    end else if (|portAFall) begin
                        state_q <= WWU_OSC_WAIT; // [R10] [R14]
                        pendResume_q <= 1'b1;
                        pendIrq_q <= 1'b0;
                    end
                end
                WWU_OSC_WAIT: begin
                    // Slow crystal readiness is not awaited [R19]
                    if (!wakeToFast || fastClockStable) begin
                        state_q <= WWU_RUN; // [R18]
                        cpuRun <= 1'b1;
                        resumeAfterHalt <= pendResume_q; // [R14] [R15]
                        irqAccept <= pendIrq_q; // [R16]
                        pendResume_q <= 1'b0;
                        pendIrq_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= WWU_RUN;
                    cpuRun <= 1'b1;
                end
            endcase
        end
    end
endmodule // wwu_watchdog_wakeup

//--- verif/wwu_watchdog_wakeup_asserts.sv
`timescale 1ns/10ps
module wwu_watchdog_wakeup_asserts (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic haltInstr,
    input wire logic wakeToFast,
    input wire logic fastClockStable,
    input wire logic deviceReset,
    input wire logic pcSpReset,
    input wire logic fullReset,
    input wire logic resumeAfterHalt,
    input wire logic irqAccept,
    input wire logic cpuRun
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // Bus steps
    // ----------------------------------------
    sequence sSetup;
        psel && !penable;
    endsequence
    sequence sBadRead;
        psel && !penable && !pwrite && paddr > 8'h10;
    endsequence
    a_pready_setup: assert property (sSetup |=> pready)
        else $error("no ready after setup");
    a_pready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_slverr_qual: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    a_unmapped_rd: assert property (sBadRead |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    // ----------------------------------------
    // Reset and wake
    // ----------------------------------------
    a_rst_pulse: assert property (deviceReset |=> !deviceReset)
        else $error("device reset longer than one cycle");
    a_wake_excl: assert property (fullReset |-> !pcSpReset && !deviceReset)
        else $error("pin wake not exclusive");
    a_halt_stops: assert property (haltInstr && cpuRun |-> ##[1:3] !cpuRun)
        else $error("halt did not stop cpu");
    a_osc_gate: assert property ($rose(cpuRun) |->
        !$past(wakeToFast) || $past(fastClockStable))
        else $error("cpu started before fast clock stable");
    a_resume_run: assert property (resumeAfterHalt || irqAccept |->
        ##[0:1] cpuRun)
        else $error("resume without cpu running");
endmodule // wwu_watchdog_wakeup_asserts

//--- verif/watchdog_and_wakeup_control_tb.sv
`timescale 1ns/10ps
`include "wwu_regs.svh"
module watchdog_and_wakeup_control_tb;
    import wwu_pkg::*;
    logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, errSeen;
    logic [7:0] paddr, portAIn, irqRequest, irqEnable, irqWakeSource;
    logic [31:0] pwdata, prdata, rd;
    logic slowRcTick, clearWatchdogInstr, haltInstr, wakeToFast;
    logic fastClockStable, externalResetPinN, resetPinSelect, stackFull;
    logic deviceReset, pcSpReset, fullReset, resumeAfterHalt, irqAccept, cpuRun;
    int num_errors, n_tests, nDev, nPc, nFull, nRes, nAcc, k, p, key;
    wwu_watchdog_wakeup u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slowRcTick(slowRcTick), .clearWatchdogInstr(clearWatchdogInstr),
        .haltInstr(haltInstr), .wakeToFast(wakeToFast),
        .fastClockStable(fastClockStable),
        .externalResetPinN(externalResetPinN),
        .resetPinSelect(resetPinSelect), .portAIn(portAIn),
        .irqRequest(irqRequest), .irqEnable(irqEnable), .stackFull(stackFull),
        .deviceReset(deviceReset), .pcSpReset(pcSpReset),
        .fullReset(fullReset), .resumeAfterHalt(resumeAfterHalt),
        .irqAccept(irqAccept), .irqWakeSource(irqWakeSource), .cpuRun(cpuRun));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (deviceReset === 1'b1) nDev++;
        if (pcSpReset === 1'b1) nPc++;
        if (fullReset === 1'b1) nFull++;
        if (resumeAfterHalt === 1'b1) nRes++;
        if (irqAccept === 1'b1) nAcc++;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic int ratioOf(input int code);
        int expo[8] = '{8, 10, 12, 14, 15, 16, 17, 18};
        return 1 << expo[code];
    endfunction
    task conclude();
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task tick(input int n);
        repeat (n) begin
            slowRcTick <= 1'b1;
            @(posedge sys_clk);
            slowRcTick <= 1'b0;
            repeat ($urandom_range(1, 3)) @(posedge sys_clk);
        end
        repeat (3) @(posedge sys_clk);
    endtask
    task clrWdog();
        clearWatchdogInstr <= 1'b1;
        @(posedge sys_clk);
        clearWatchdogInstr <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    task halt();
        nDev = 0; nPc = 0; nFull = 0; nRes = 0; nAcc = 0;
        haltInstr <= 1'b1;
        @(posedge sys_clk);
        haltInstr <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task waitRun();
        k = 0;
        while (cpuRun !== 1'b1 && k < 200) begin
            @(posedge sys_clk);
            k++;
        end
        chk(k < 200, 1);
        repeat (2) @(posedge sys_clk);
    endtask
    initial begin
        #400000;
        num_errors++;
        conclude();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {sys_rst, psel, penable, pwrite, slowRcTick} = 5'h10;
        {paddr, pwdata} = 40'h0;
        {clearWatchdogInstr, haltInstr, wakeToFast, stackFull} = 4'h0;
        {fastClockStable, externalResetPinN, resetPinSelect} = 3'h6;
        {portAIn, irqRequest, irqEnable} = 24'hFF0000;
        num_errors = 0; n_tests = 0; nDev = 0; nPc = 0;
        nFull = 0; nRes = 0; nAcc = 0;
        k = $urandom(48809);
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rdchk(`WWU_OFS_WDOG_CTRL, 32'h53);
        rdchk(`WWU_OFS_RST_FLAGS, 32'h0);
        rdchk(`WWU_OFS_STATUS, 32'h0);
        rdchk(`WWU_OFS_WAKE_EN, 32'h0);
        rdchk(8'h20, 32'h0);
        chk(errSeen, 1);
        for (p = 0; p < 2; p++) begin
            apb(1'b1, `WWU_OFS_WDOG_CTRL, 32'h50 | p);
            clrWdog();
            nDev = 0;
            tick(ratioOf(p) - 1);
            chk(nDev, 0);
            tick(1);
            chk(nDev, 1);
            rdchk(`WWU_OFS_STATUS, 32'h1);
        end
        apb(1'b1, `WWU_OFS_WDOG_CTRL, 32'h50);
        clrWdog();
        nDev = 0;
        tick($urandom_range(50, 250));
        clrWdog();
        tick(200);
        resetPinSelect <= 1'b1;
        externalResetPinN <= 1'b0;
        @(posedge sys_clk);
        externalResetPinN <= 1'b1;
        tick(200);
        chk(nDev, 0);
        apb(1'b1, `WWU_OFS_WDOG_CTRL, 32'hA8);
        tick(300);
        chk(nDev, 0);
        do key = $urandom_range(0, 31); while (key == 5'h15 || key == 5'h0A);
        apb(1'b1, `WWU_OFS_WDOG_CTRL, key << 3);
        k = 0;
        while (nDev == 0 && k < 300) begin
            @(posedge sys_clk);
            k++;
        end
        chk(k >= `WWU_SRESET_CYCLES - 4 && k <= `WWU_SRESET_CYCLES + 4, 1);
        rdchk(`WWU_OFS_RST_FLAGS, 32'h1);
        apb(1'b1, `WWU_OFS_RST_FLAGS, 32'h1);
        rdchk(`WWU_OFS_RST_FLAGS, 32'h1);
        apb(1'b1, `WWU_OFS_RST_FLAGS, 32'h0);
        rdchk(`WWU_OFS_RST_FLAGS, 32'h0);
        apb(1'b1, `WWU_OFS_WDOG_CTRL, 32'h50);
        clrWdog();
        wakeToFast <= 1'b1;
        fastClockStable <= 1'b0;
        halt();
        rdchk(`WWU_OFS_STATUS, 32'h2);
        tick(256);
        chk(nPc, 1);
        chk(nDev, 0);
        chk(cpuRun, 0);
        rdchk(`WWU_OFS_POWER_STATE, 32'h1);
        fastClockStable <= 1'b1;
        waitRun();
        rdchk(`WWU_OFS_POWER_STATE, 32'h0);
        rdchk(`WWU_OFS_STATUS, 32'h3);
        clrWdog();
        rdchk(`WWU_OFS_STATUS, 32'h1);
        p = $urandom_range(0, 7);
        apb(1'b1, `WWU_OFS_WAKE_EN, 32'h1 << p);
        halt();
        portAIn[(p + 1) % 8] <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(cpuRun, 0);
        portAIn[p] <= 1'b0;
        waitRun();
        chk(nRes, 1);
        portAIn <= 8'hFF;
        irqRequest <= 8'h01;
        irqEnable <= 8'hFF;
        halt();
        repeat (8) @(posedge sys_clk);
        chk(cpuRun, 0);
        irqRequest <= 8'h03;
        waitRun();
        chk(nAcc, 1);
        chk(irqWakeSource, 32'h02);
        for (p = 0; p < 2; p++) begin
            irqRequest <= 8'h00;
            halt();
            irqEnable <= p ? 8'hFF : 8'h00;
            stackFull <= p;
            irqRequest <= 8'h04;
            waitRun();
            chk(nRes, 1);
            chk(nAcc, 0);
        end
        irqRequest <= 8'h00;
        stackFull <= 1'b0;
        halt();
        externalResetPinN <= 1'b0;
        repeat (4) @(posedge sys_clk);
        externalResetPinN <= 1'b1;
        waitRun();
        chk(nFull, 1);
        chk(nPc, 0);
        conclude();
    end
endmodule // watchdog_and_wakeup_control_tb

bind wwu_watchdog_wakeup wwu_watchdog_wakeup_asserts u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .haltInstr(haltInstr), .wakeToFast(wakeToFast),
    .fastClockStable(fastClockStable), .deviceReset(deviceReset),
    .pcSpReset(pcSpReset), .fullReset(fullReset),
    .resumeAfterHalt(resumeAfterHalt), .irqAccept(irqAccept), .cpuRun(cpuRun));
